//--- core/tfpi_pkg.sv
/*
  tfpi_pkg: object dictionary indices, mapping entries, image layout and
  timing constants for the transponder process image framer.
  assumes nothing of its surroundings; imported by the framer and the testbench.
*/
package tfpi_pkg;
  // dictionary indices
  localparam logic [15:0] TX_MAP_ONE_IDX   = 16'h1a00;
  localparam logic [15:0] TX_MAP_TWO_IDX   = 16'h1a01;
  localparam logic [15:0] BYTE_INPUTS_IDX  = 16'h6000;
  localparam logic [15:0] WORD_INPUTS_IDX  = 16'h6100;
  localparam logic [15:0] CODE_INPUT_IDX   = 16'h6120;
  localparam logic [15:0] NEW_CODE_IDX     = 16'h6320;
  localparam logic [15:0] LEVEL_INPUTS_IDX = 16'h6401;
  // subentry counts (subentry zero values)
  localparam logic [7:0]  TX_MAP_ONE_CNT   = 8'h03;
  localparam logic [7:0]  TX_MAP_TWO_CNT   = 8'h06;
  localparam logic [7:0]  BYTE_INPUTS_CNT  = 8'h05;
  localparam logic [7:0]  SINGLE_CNT       = 8'h01;
  localparam logic [7:0]  LEVEL_INPUTS_CNT = 8'h02;
  // mapping entries of the two transmit objects
  localparam logic [31:0] MAP1_E1 = 32'h61000110;
  localparam logic [31:0] MAP1_E2 = 32'h61200120;
  localparam logic [31:0] MAP1_E3 = 32'h60000108;
  localparam logic [31:0] MAP2_E1 = 32'h64010110;
  localparam logic [31:0] MAP2_E2 = 32'h64010210;
  localparam logic [31:0] MAP2_E3 = 32'h60000208;
  localparam logic [31:0] MAP2_E4 = 32'h60000308;
  localparam logic [31:0] MAP2_E5 = 32'h60000408;
  localparam logic [31:0] MAP2_E6 = 32'h60000508;
  // payload sizes in bytes
  localparam int PDO1_BYTES  = 7;
  localparam int PDO2_BYTES  = 8;
  localparam int IMAGE_BYTES = 12;
  localparam int OUT_BYTES   = 4;
  // reset values
  localparam logic [31:0] NEW_CODE_RESET = 32'h00000000;
  // programming time
  localparam int CLK_HZ      = 20_000_000;
  localparam int PROG_MS     = 50;
  localparam int PROG_CYCLES = CLK_HZ / 1000 * PROG_MS;
  // frame kinds
  typedef enum logic [1:0] {TFPI_PDO1, TFPI_PDO2, TFPI_IMAGE} tfpi_kind_t;
endpackage : tfpi_pkg

//--- core/tfpi_buf.sv
/*
  tfpi_buf: two-entry byte buffer with valid/ready on both sides.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module tfpi_buf (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [8:0] wr_data_in,
  input  wire logic       wr_valid_in,
  output logic            wr_ready_out,
  output logic [8:0]      rd_data_out,
  output logic            rd_valid_out,
  input  wire logic       rd_ready_in
);
  logic [8:0] mem [2];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;
  wire        do_wr = wr_valid_in && wr_ready_out;
  wire        do_rd = rd_valid_out && rd_ready_in;

  // honest full and empty
  assign wr_ready_out = (count != 2'd2);
  assign rd_valid_out = (count != 2'd0);
  assign rd_data_out  = mem[rd_ptr];

  // pointer and occupancy update
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
    end else begin
      if (do_wr) begin
        mem[wr_ptr] <= wr_data_in;
        wr_ptr      <= ~wr_ptr;
      end
      if (do_rd) rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, do_wr} - {1'b0, do_rd};
    end
  end
endmodule : tfpi_buf

//--- core/tfpi_framer.sv
/*
  tfpi_framer: builds transmit objects one and two and the 12-byte input
  image from one snapshot of the antenna values, serves read-only
  dictionary lookups, and takes the 4-byte new-code output image.
  assumes the antenna values are on this clock; the master bytes arrive
  as one-cycle strobes from the bus controller on the same clock.
*/
`timescale 1ns/1ns
module tfpi_framer
  import tfpi_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RESET_IN,
  input  wire logic [15:0] STATUS1_IN,
  input  wire logic [31:0] CODE_IN,
  input  wire logic [7:0]  READ_COUNT_IN,
  input  wire logic [15:0] SUM_LEVEL_IN,
  input  wire logic [15:0] DIFF_LEVEL_IN,
  input  wire logic [7:0]  DEBUG_COUNT_IN,
  input  wire logic        SUM_FAULT_IN,
  input  wire logic        DIFF_FAULT_IN,
  input  wire logic [7:0]  STATUS2_IN,
  input  wire logic [31:0] STORED_CODE_IN,
  input  wire logic        SEND_IN,
  input  wire logic [1:0]  KIND_IN,
  output logic             SEND_READY_OUT,
  output logic [7:0]       TX_BYTE_OUT,
  output logic             TX_LAST_OUT,
  output logic             TX_VALID_OUT,
  input  wire logic        TX_READY_IN,
  input  wire logic [7:0]  RX_BYTE_IN,
  input  wire logic        RX_VALID_IN,
  input  wire logic        RX_FIRST_IN,
  output logic [31:0]      NEW_CODE_OUT,
  output logic             PROG_START_OUT,
  output logic             PROG_BUSY_OUT,
  input  wire logic [15:0] OD_INDEX_IN,
  input  wire logic [7:0]  OD_SUB_IN,
  output logic [31:0]      OD_DATA_OUT,
  output logic             OD_VALID_OUT
);
  typedef enum logic [1:0] {TFPI_IDLE, TFPI_SEND} tfpi_state_t;
  tfpi_state_t state;
  logic [7:0]  snap [IMAGE_BYTES];
  logic [3:0]  idx;
  logic [3:0]  last_idx;
  logic [1:0]  kind;
  logic [7:0]  sum_faults;
  logic [7:0]  diff_faults;
  logic [7:0]  telegrams;
  logic [31:0] rx_shift;
  logic [1:0]  rx_cnt;
  logic [31:0] prog_cnt;
  logic        buf_ready;
  logic [8:0]  buf_out;
  wire  [7:0]  live [IMAGE_BYTES];

  // live image in input-image order; objects reuse slices of it
  assign live[0]  = STATUS1_IN[7:0];
  assign live[1]  = STATUS1_IN[15:8];
  assign live[2]  = CODE_IN[7:0];
  assign live[3]  = CODE_IN[15:8];
  assign live[4]  = CODE_IN[23:16];
  assign live[5]  = CODE_IN[31:24];
  assign live[6]  = READ_COUNT_IN;
  assign live[7]  = SUM_LEVEL_IN[7:0];
  assign live[8]  = SUM_LEVEL_IN[15:8];
  assign live[9]  = DIFF_LEVEL_IN[7:0];
  assign live[10] = DIFF_LEVEL_IN[15:8];
  assign live[11] = telegrams;

  // byte select per frame kind; object two tail holds byte group subentries 2 to 5
  wire [7:0] pdo2_tail [4];
  assign pdo2_tail[0] = DEBUG_COUNT_IN;
  assign pdo2_tail[1] = sum_faults;
  assign pdo2_tail[2] = diff_faults;
  assign pdo2_tail[3] = STATUS2_IN;
  logic [7:0] tail_snap [4];
  wire [7:0] pdo2_byte = (idx < 4'd4) ? snap[4'd7 + idx] : tail_snap[idx[1:0]];
  wire [7:0] cur_byte  = (kind == TFPI_PDO2) ? pdo2_byte : snap[idx];
  wire [3:0] kind_last = (KIND_IN == TFPI_PDO1) ? 4'(PDO1_BYTES - 1) :
                         (KIND_IN == TFPI_PDO2) ? 4'(PDO2_BYTES - 1) :
                         4'(IMAGE_BYTES - 1);
  assign SEND_READY_OUT = (state == TFPI_IDLE);
  wire start = SEND_IN && SEND_READY_OUT && (KIND_IN != 2'd3);
  wire push  = (state == TFPI_SEND);

  // frame sequencer: snapshot on start, then stream bytes
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      state     <= TFPI_IDLE;
      idx       <= 4'h0;
      last_idx  <= 4'h0;
      kind      <= 2'd0;
      telegrams <= 8'h00;
    end else begin
      case (state)
        TFPI_IDLE: begin
          if (start) begin
            state    <= TFPI_SEND;
            idx      <= 4'h0;
            last_idx <= kind_last;
            kind     <= KIND_IN;
            if (KIND_IN == TFPI_IMAGE) telegrams <= telegrams + 8'h01;
          end
        end
        TFPI_SEND: begin
          if (buf_ready) begin
            if (idx == last_idx) state <= TFPI_IDLE;
            else idx <= idx + 4'h1;
          end
        end
        default: state <= TFPI_IDLE;
      endcase
    end
  end

  // snapshot of every field at frame start
  genvar g;
  generate
    for (g = 0; g < IMAGE_BYTES; g++) begin : g_snap
      always_ff @(posedge CLOCK_IN) begin
        if (start) snap[g] <= live[g];
      end
    end
    for (g = 0; g < 4; g++) begin : g_tail
      always_ff @(posedge CLOCK_IN) begin
        if (start) tail_snap[g] <= pdo2_tail[g];
      end
    end
  endgenerate

  // separate fault counters
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      sum_faults  <= 8'h00;
      diff_faults <= 8'h00;
    end else begin
      if (SUM_FAULT_IN)  sum_faults  <= sum_faults + 8'h01;
      if (DIFF_FAULT_IN) diff_faults <= diff_faults + 8'h01;
    end
  end

  tfpi_buf u_buf (
    .clk_in       (CLOCK_IN),
    .rst_in       (RESET_IN),
    .wr_data_in   ({idx == last_idx, cur_byte}),
    .wr_valid_in  (push),
    .wr_ready_out (buf_ready),
    .rd_data_out  (buf_out),
    .rd_valid_out (TX_VALID_OUT),
    .rd_ready_in  (TX_READY_IN)
  );
  assign TX_BYTE_OUT = buf_out[7:0];
  assign TX_LAST_OUT = buf_out[8];

  // output image assembly, low byte first, and programming trigger
  wire [31:0] rx_word = {RX_BYTE_IN, rx_shift[31:8]};
  wire        rx_done = RX_VALID_IN && (RX_FIRST_IN ? 1'b0 : rx_cnt == 2'd3);
  wire        changed = rx_done && (rx_word != NEW_CODE_OUT);
  assign PROG_BUSY_OUT = (prog_cnt != 32'd0);
  always_ff @(posedge CLOCK_IN) begin
    if (RESET_IN) begin
      rx_shift       <= 32'h0;
      rx_cnt         <= 2'd0;
      NEW_CODE_OUT   <= NEW_CODE_RESET;
      PROG_START_OUT <= 1'b0;
      prog_cnt       <= 32'd0;
    end else begin
      PROG_START_OUT <= 1'b0;
      if (PROG_BUSY_OUT) prog_cnt <= prog_cnt - 32'd1;
      if (RX_VALID_IN) begin
        rx_shift <= RX_FIRST_IN ? {RX_BYTE_IN, 24'h0} : rx_word;
        rx_cnt   <= RX_FIRST_IN ? 2'd1 : rx_cnt + 2'd1;
      end
      if (changed) begin
        NEW_CODE_OUT <= rx_word;
        if (rx_word != STORED_CODE_IN) begin
          PROG_START_OUT <= 1'b1;
          prog_cnt       <= 32'(PROG_CYCLES);
        end
      end
    end
  end

  // read-only dictionary lookup
  logic [31:0] od;
  always_comb begin
    od = 32'h0;
    OD_VALID_OUT = 1'b1;
    case (OD_INDEX_IN)
      TX_MAP_ONE_IDX: case (OD_SUB_IN)
        8'h00: od = {24'h0, TX_MAP_ONE_CNT};
        8'h01: od = MAP1_E1;
        8'h02: od = MAP1_E2;
        8'h03: od = MAP1_E3;
        default: OD_VALID_OUT = 1'b0;
      endcase
      TX_MAP_TWO_IDX: case (OD_SUB_IN)
        8'h00: od = {24'h0, TX_MAP_TWO_CNT};
        8'h01: od = MAP2_E1;
        8'h02: od = MAP2_E2;
        8'h03: od = MAP2_E3;
        8'h04: od = MAP2_E4;
        8'h05: od = MAP2_E5;
        8'h06: od = MAP2_E6;
        default: OD_VALID_OUT = 1'b0;
      endcase
      BYTE_INPUTS_IDX: case (OD_SUB_IN)
        8'h00: od = {24'h0, BYTE_INPUTS_CNT};
        8'h01: od = {24'h0, READ_COUNT_IN};
        8'h02: od = {24'h0, DEBUG_COUNT_IN};
        8'h03: od = {24'h0, sum_faults};
        8'h04: od = {24'h0, diff_faults};
        8'h05: od = {24'h0, STATUS2_IN};
        default: OD_VALID_OUT = 1'b0;
      endcase
      WORD_INPUTS_IDX: case (OD_SUB_IN)
        8'h00: od = {24'h0, SINGLE_CNT};
        8'h01: od = {16'h0, STATUS1_IN};
        default: OD_VALID_OUT = 1'b0;
      endcase
      CODE_INPUT_IDX: case (OD_SUB_IN)
        8'h00: od = {24'h0, SINGLE_CNT};
        8'h01: od = CODE_IN;
        default: OD_VALID_OUT = 1'b0;
      endcase
      NEW_CODE_IDX: case (OD_SUB_IN)
        8'h00: od = {24'h0, SINGLE_CNT};
        8'h01: od = NEW_CODE_OUT;
        default: OD_VALID_OUT = 1'b0;
      endcase
      LEVEL_INPUTS_IDX: case (OD_SUB_IN)
        8'h00: od = {24'h0, LEVEL_INPUTS_CNT};
        8'h01: od = {16'h0, SUM_LEVEL_IN};
        8'h02: od = {{16{DIFF_LEVEL_IN[15]}}, DIFF_LEVEL_IN};
        default: OD_VALID_OUT = 1'b0;
      endcase
      default: OD_VALID_OUT = 1'b0;
    endcase
  end
  assign OD_DATA_OUT = od;

  // assertions
  property p_prog_on_change;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      (changed && rx_word != STORED_CODE_IN) |=> PROG_START_OUT && PROG_BUSY_OUT;
  endproperty
  a_prog_on_change: assert property (p_prog_on_change) else $error("no prog start");
  property p_no_prog_no_change;
    @(posedge CLOCK_IN) disable iff (RESET_IN) !changed |=> !PROG_START_OUT;
  endproperty
  a_no_prog_no_change: assert property (p_no_prog_no_change) else $error("spurious prog");
  property p_new_code;
    @(posedge CLOCK_IN) disable iff (RESET_IN) changed |=> NEW_CODE_OUT == $past(rx_word);
  endproperty
  a_new_code: assert property (p_new_code) else $error("new code wrong");
  property p_image_status;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      start && KIND_IN == TFPI_IMAGE |=>
        snap[0] == $past(STATUS1_IN[7:0]) && snap[1] == $past(STATUS1_IN[15:8]);
  endproperty
  a_image_status: assert property (p_image_status) else $error("status bytes");
  property p_image_code;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      start |=> {snap[5], snap[4], snap[3], snap[2]} == $past(CODE_IN);
  endproperty
  a_image_code: assert property (p_image_code) else $error("code bytes");
  property p_image_diff;
    @(posedge CLOCK_IN) disable iff (RESET_IN) start |=> {snap[10], snap[9]} == $past(DIFF_LEVEL_IN);
  endproperty
  a_image_diff: assert property (p_image_diff) else $error("diff bytes");
  property p_byte_count;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      OD_INDEX_IN == BYTE_INPUTS_IDX && OD_SUB_IN == 8'h00 |-> OD_DATA_OUT == 32'h5;
  endproperty
  a_byte_count: assert property (p_byte_count) else $error("byte group count");
  property p_sum_fault;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      SUM_FAULT_IN |=> sum_faults == $past(sum_faults) + 8'h01;
  endproperty
  a_sum_fault: assert property (p_sum_fault) else $error("sum fault count");
  property p_frame_len;
    @(posedge CLOCK_IN) disable iff (RESET_IN)
      start && KIND_IN == TFPI_PDO1 |=> last_idx == 4'd6;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("object one length");
  c_image: cover property (@(posedge CLOCK_IN) start && KIND_IN == TFPI_IMAGE);
  c_pdo2: cover property (@(posedge CLOCK_IN) start && KIND_IN == TFPI_PDO2);
  c_prog: cover property (@(posedge CLOCK_IN) PROG_START_OUT);
  c_stall: cover property (@(posedge CLOCK_IN) TX_VALID_OUT && !TX_READY_IN);
endmodule : tfpi_framer

//--- testbench/tfpi_master_model.sv
/*
  tfpi_master_model: fieldbus master seen from the framer; takes the
  transmit bytes with an optionally stalling ready and sends the 4-byte
  new-code output image.
  assumes the framer's clock; signals change on the falling edge.
*/
`timescale 1ns/1ns
module tfpi_master_model (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       slow_in,
  input  wire logic [7:0] tx_byte_in,
  input  wire logic       tx_last_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out,
  output logic [7:0]      rx_byte_out,
  output logic            rx_valid_out,
  output logic            rx_first_out
);
  logic [7:0] got [64];
  logic       last_seen [64];
  int         n = 0;
  logic       phase = 1'b0;
  initial begin
    tx_ready_out = 1'b0;
    rx_byte_out  = 8'h00;
    rx_valid_out = 1'b0;
    rx_first_out = 1'b0;
  end
  // ready stalls every other cycle when slow
  always @(negedge clk_in) begin
    phase        <= ~phase;
    tx_ready_out <= ~slow_in | phase;
  end
  // bytes taken where valid meets ready
  always @(posedge clk_in) begin
    if (!rst_in && tx_valid_in && tx_ready_out) begin
      got[n]       = tx_byte_in;
      last_seen[n] = tx_last_in;
      n            = n + 1;
    end
  end
  // new code, low byte first; released line shows the inverse
  task automatic send_code(input logic [31:0] c);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_in);
      rx_byte_out  = c[8*i +: 8];
      rx_valid_out = 1'b1;
      rx_first_out = (i == 0);
    end
    @(negedge clk_in);
    rx_valid_out = 1'b0;
    rx_first_out = 1'b0;
    rx_byte_out  = ~rx_byte_out;
  endtask : send_code
endmodule : tfpi_master_model

//--- testbench/tfpi_framer_tb.sv
/*
  tfpi_framer_tb: dictionary reads, the three frame kinds and new-code
  programming, checked against values worked out here.
  assumes the framer and the master model; inputs move on falling edges.
*/
`timescale 1ns/1ns
module tfpi_framer_tb;
  import tfpi_pkg::*;
  logic        clock_in = 1'b0, reset_in = 1'b1, slow = 1'b0;
  logic [15:0] st1 = 16'ha51c, sum = 16'hbeef, diff = 16'hff85;
  logic [31:0] code = 32'h12345678, stored = 32'h00000abc;
  logic [7:0]  cnt = 8'h2c, dbg = 8'h3d, st2 = 8'h96, tel = 8'h00;
  logic        sfault = 1'b0, dfault = 1'b0, send = 1'b0;
  logic [1:0]  kind = 2'h0;
  logic [15:0] od_idx = 16'h0000;
  logic [7:0]  od_sub = 8'h00;
  logic [7:0]  rx_byte, tx_byte, exp [12];
  logic        send_ready, tx_last, tx_valid, tx_ready, rx_valid, rx_first;
  logic        prog_start, prog_busy, od_valid;
  logic [31:0] new_code, od_data;
  int          n_mismatch = 0, checks = 0, cycles = 0, n_start = 0;
  logic [55:0] tab [17] = '{
    56'h1a0000_00000003, 56'h1a0001_61000110, 56'h1a0002_61200120, 56'h1a0003_60000108,
    56'h1a0100_00000006, 56'h1a0101_64010110, 56'h1a0102_64010210, 56'h1a0103_60000208,
    56'h1a0104_60000308, 56'h1a0105_60000408, 56'h1a0106_60000508, 56'h600000_00000005,
    56'h610000_00000001, 56'h612000_00000001, 56'h632000_00000001, 56'h640100_00000002,
    56'h632001_00000000};

  tfpi_framer tfpi_framer_inst (.CLOCK_IN(clock_in), .RESET_IN(reset_in), .STATUS1_IN(st1),
    .CODE_IN(code), .READ_COUNT_IN(cnt), .SUM_LEVEL_IN(sum), .DIFF_LEVEL_IN(diff),
    .DEBUG_COUNT_IN(dbg), .SUM_FAULT_IN(sfault), .DIFF_FAULT_IN(dfault), .STATUS2_IN(st2),
    .STORED_CODE_IN(stored), .SEND_IN(send), .KIND_IN(kind), .SEND_READY_OUT(send_ready),
    .TX_BYTE_OUT(tx_byte), .TX_LAST_OUT(tx_last), .TX_VALID_OUT(tx_valid),
    .TX_READY_IN(tx_ready), .RX_BYTE_IN(rx_byte), .RX_VALID_IN(rx_valid),
    .RX_FIRST_IN(rx_first), .NEW_CODE_OUT(new_code), .PROG_START_OUT(prog_start),
    .PROG_BUSY_OUT(prog_busy), .OD_INDEX_IN(od_idx), .OD_SUB_IN(od_sub),
    .OD_DATA_OUT(od_data), .OD_VALID_OUT(od_valid));
  tfpi_master_model master_inst (.clk_in(clock_in), .rst_in(reset_in), .slow_in(slow),
    .tx_byte_in(tx_byte), .tx_last_in(tx_last), .tx_valid_in(tx_valid),
    .tx_ready_out(tx_ready), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
    .rx_first_out(rx_first));

  // clock, cycle ceiling and start pulse count
  always #25 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles++;
    if (prog_start === 1'b1) n_start++;
    if (cycles == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : chk

  task automatic od(input logic [15:0] i, input logic [7:0] s, input logic [31:0] e,
                    input logic v);
    @(negedge clock_in);
    od_idx = i;
    od_sub = s;
    #10;
    chk(od_data, e);
    chk({31'h0, od_valid}, {31'h0, v});
  endtask : od

  // one frame; inputs flip after the taking edge to prove the snapshot
  task automatic frame(input logic [1:0] k, input int nb);
    int b;
    b = master_inst.n;
    if (k == 2'h0) exp = '{st1[7:0], st1[15:8], code[7:0], code[15:8], code[23:16],
                           code[31:24], cnt, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    if (k == 2'h1) exp = '{sum[7:0], sum[15:8], diff[7:0], diff[15:8], dbg, 8'h03, 8'h01,
                           st2, 8'h00, 8'h00, 8'h00, 8'h00};
    if (k == 2'h2) exp = '{st1[7:0], st1[15:8], code[7:0], code[15:8], code[23:16],
                           code[31:24], cnt, sum[7:0], sum[15:8], diff[7:0], diff[15:8], tel};
    if (k == 2'h2) tel = tel + 8'h01; // counter steps after its value is taken
    @(negedge clock_in);
    send = 1'b1;
    kind = k;
    @(negedge clock_in);
    send = 1'b0;
    {st1, code, cnt, sum, diff, dbg, st2} = ~{st1, code, cnt, sum, diff, dbg, st2};
    chk({31'h0, send_ready}, 32'h0);
    for (int i = 0; i < 300 && master_inst.n < b + nb; i++) @(negedge clock_in);
    repeat (4) @(negedge clock_in);
    chk(master_inst.n, b + nb);
    for (int i = 0; i < nb; i++) begin
      chk(master_inst.got[b+i], exp[i]);
      chk({31'h0, master_inst.last_seen[b+i]}, {31'h0, i == nb - 1});
    end
  endtask : frame

  task automatic final_report();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    repeat (2) @(negedge clock_in);
    reset_in = 1'b0;
    foreach (tab[i]) od(tab[i][55:40], tab[i][39:32], tab[i][31:0], 1'b1);
    od(16'h1234, 8'h00, 32'h0, 1'b0);
    $display("test dictionary done");
    for (int i = 0; i < 3; i++) begin
      @(negedge clock_in);
      sfault = 1'b1;
      dfault = (i == 0);
      @(negedge clock_in);
      sfault = 1'b0;
      dfault = 1'b0;
    end
    od(16'h6000, 8'h03, 32'h3, 1'b1);
    sfault = 1'b0;
    @(negedge clock_in);
    od(16'h6000, 8'h04, 32'h1, 1'b1);
    od(16'h6000, 8'h01, {24'h0, cnt}, 1'b1);
    od(16'h6000, 8'h02, {24'h0, dbg}, 1'b1);
    od(16'h6000, 8'h05, {24'h0, st2}, 1'b1);
    od(16'h6401, 8'h01, {16'h0, sum}, 1'b1);
    od(16'h6401, 8'h02, {{16{diff[15]}}, diff}, 1'b1);
    od(16'h6100, 8'h01, {16'h0, st1}, 1'b1);
    od(16'h6120, 8'h01, code, 1'b1);
    $display("test live values done");
    frame(2'h0, 7);
    frame(2'h1, 8);
    slow = 1'b1;
    frame(2'h2, 12);
    frame(2'h2, 12);
    slow = 1'b0;
    @(negedge clock_in);
    send = 1'b1;
    kind = 2'h3;
    repeat (3) @(negedge clock_in);
    send = 1'b0;
    chk(master_inst.n, 39);
    $display("test frames done");
    master_inst.send_code(32'h0badcafe);
    repeat (2) @(negedge clock_in);
    chk(new_code, 32'h0badcafe);
    chk(n_start, 1);
    chk({31'h0, prog_busy}, 32'h1);
    od(16'h6320, 8'h01, 32'h0badcafe, 1'b1);
    master_inst.send_code(32'h0badcafe);
    repeat (2) @(negedge clock_in);
    chk(n_start, 1);
    master_inst.send_code(stored);
    repeat (2) @(negedge clock_in);
    chk(new_code, stored);
    chk(n_start, 1);
    $display("test programming done");
    final_report();
  end
endmodule : tfpi_framer_tb
